// ### srw_pkg.sv
// Package for the serial register write handler: constants and types
// Behaviour
// R1: Function 06H writes exactly one holding register
// R2: Single write goes to received high-first address
// R3: Function 10H writes several consecutive registers
// R4: Words land at start, then next higher
// R5: Byte count must equal twice register count
// R6: Frequency and forward_run apply from one frame
// R7: Loop-back 08H echoes test code and data
// R8: Master zeroes unused bits, avoids reserved registers
// R9: Echo on success; function|80H plus code otherwise
`default_nettype none
package srw_pkg;
  // ----------------------------------------------------------------
  // Function and exception codes, broadcast node address
  // ----------------------------------------------------------------
  localparam logic [7:0] FN_WRITE_ONE = 8'h06;
  localparam logic [7:0] FN_WRITE_MANY = 8'h10;
  localparam logic [7:0] FN_LOOPBACK = 8'h08;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
  localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
  localparam logic [7:0] NODE_BROADCAST = 8'h00;
  // ----------------------------------------------------------------
  // Frame positions and response lengths
  // ----------------------------------------------------------------
  localparam logic [2:0] POS_BYTE_COUNT = 3'h6;
  localparam logic [2:0] POS_DATA = 3'h7;
  localparam logic [2:0] POS_LAST_FIXED = 3'h5;
  localparam logic [2:0] RSP_LEN_OK = 3'h6;
  localparam logic [2:0] RSP_LEN_EXC = 3'h3;
  // ----------------------------------------------------------------
  // Handler states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SRW_RX = 1'b0,
    SRW_RESP = 1'b1
  } srw_state_t;
endpackage
`default_nettype wire

// ### srw_wr_if.sv
// Interface carrying register write requests between handler and buffer
`timescale 1ns/10ps
`default_nettype none
interface srw_wr_if;
  logic valid;
  logic ready;
  logic [15:0] addr;
  logic [15:0] data;
  modport src (output valid, output addr, output data, input ready);
  modport snk (input valid, input addr, input data, output ready);
endinterface
`default_nettype wire

// ### srw_wr_buf.sv
// Two-entry buffer holding register writes until the register space takes them
`timescale 1ns/10ps
`default_nettype none
module srw_wr_buf (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Write requests from the handler
  srw_wr_if.snk wr,
  // Write port toward the register space
  output logic reg_wr_valid_out,
  output logic [15:0] reg_wr_addr_out,
  output logic [15:0] reg_wr_data_out,
  input wire logic reg_wr_ready_in
);
  typedef struct packed {
    logic [1:0][31:0] ent;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } srw_buf_t;

  srw_buf_t cur;
  srw_buf_t next_cur;
  logic push;
  logic pop;

  // Ready drops once both entries hold a word, stalling the handler
  assign wr.ready = (cur.cnt != 2'h2);
  assign reg_wr_valid_out = (cur.cnt != 2'h0);
  assign reg_wr_addr_out = cur.ent[cur.rp][31:16];
  assign reg_wr_data_out = cur.ent[cur.rp][15:0];
  assign push = wr.valid && wr.ready;
  assign pop = reg_wr_valid_out && reg_wr_ready_in;

  // Next state of the buffer
  always_comb begin
    next_cur = cur;
    if (push) begin
      next_cur.ent[cur.wp] = {wr.addr, wr.data};
      next_cur.wp = ~cur.wp;
    end
    if (pop) begin
      next_cur.rp = ~cur.rp;
    end
    next_cur.cnt = cur.cnt + {1'b0, push} - {1'b0, pop};
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  a_buf_no_overrun: assert property (@(posedge clk_sys_in) // R4
    disable iff (sys_rst_in) (cur.cnt == 2'h2 && !pop) |=> cur.cnt == 2'h2)
    else $error("buffer lost or invented an entry");
endmodule // srw_wr_buf
`default_nettype wire

// ### srw_handler.sv
// Follower-side handler for single, multiple write and loop-back requests
`timescale 1ns/10ps
`default_nettype none
module srw_handler (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Own node address
  input wire logic [7:0] node_id_in,
  // Checked request bytes from the framer
  input wire logic in_valid_in,
  input wire logic [7:0] in_byte_in,
  input wire logic in_last_in,
  output logic in_ready_out,
  // Response bytes to the framer, which adds LRC or CRC-16
  output logic resp_valid_out,
  output logic [7:0] resp_byte_out,
  output logic resp_last_out,
  input wire logic resp_ready_in,
  // Holding register write port
  output logic reg_wr_valid_out,
  output logic [15:0] reg_wr_addr_out,
  output logic [15:0] reg_wr_data_out,
  input wire logic reg_wr_ready_in
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    srw_pkg::srw_state_t st;
    logic [2:0] pos;
    logic [7:0] node;
    logic [7:0] func;
    logic [7:0] hi;
    logic [15:0] start;
    logic [15:0] cnt;
    logic [15:0] k;
    logic err;
    logic [7:0] exc;
    logic [47:0] rsp;
    logic [2:0] len;
  } srw_main_t;

  srw_main_t cur;
  srw_main_t next_cur;
  srw_wr_if wr ();
  logic take;
  logic for_us;
  logic is_multi;
  logic known_func;
  logic done_ok;

  assign in_ready_out = (cur.st == srw_pkg::SRW_RX) && wr.ready;
  assign take = in_valid_in && in_ready_out;
  assign for_us = (cur.node == node_id_in) ||
                  (cur.node == srw_pkg::NODE_BROADCAST);
  assign is_multi = (cur.func == srw_pkg::FN_WRITE_MANY);
  assign known_func = (cur.func == srw_pkg::FN_WRITE_ONE) || is_multi ||
                      (cur.func == srw_pkg::FN_LOOPBACK);
  assign resp_valid_out = (cur.st == srw_pkg::SRW_RESP);
  assign resp_byte_out = cur.rsp[47:40];
  assign resp_last_out = (cur.len == 3'h1);
  // Single writes use k = 0, so one address sum serves both kinds
  assign wr.addr = cur.start + cur.k; // R4
  assign wr.data = {is_multi ? cur.hi : cur.cnt[15:8], in_byte_in};

  // ----------------------------------------------------------------
  // Request parsing and response building
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    wr.valid = 1'b0;
    done_ok = 1'b0;
    if (cur.st == srw_pkg::SRW_RX && take) begin
      if (cur.pos != srw_pkg::POS_DATA) begin
        next_cur.pos = cur.pos + 3'h1;
      end
      case (cur.pos)
        3'h0: begin
          next_cur.node = in_byte_in;
          next_cur.k = '0;
          next_cur.err = 1'b0;
          next_cur.exc = srw_pkg::EXC_BAD_VALUE;
        end
        3'h1: next_cur.func = in_byte_in;
        3'h2: next_cur.start[15:8] = in_byte_in; // R2
        3'h3: next_cur.start[7:0] = in_byte_in; // R2
        3'h4: next_cur.cnt[15:8] = in_byte_in;
        3'h5: begin
          next_cur.cnt[7:0] = in_byte_in;
          // Exactly one register for a single write
          wr.valid = for_us && (cur.func == srw_pkg::FN_WRITE_ONE); // R1
        end
        3'h6: begin
          // A count of zero or a mismatched byte count writes nothing
          if (!is_multi || in_byte_in != {cur.cnt[6:0], 1'b0} ||
              cur.cnt == 16'h0000 || cur.cnt[15:7] != 9'h000) begin
            next_cur.err = 1'b1; // R5
          end
        end
        default: begin
          // A word beyond the register count is refused, not written
          if (!cur.err && cur.k >= cur.cnt) begin
            next_cur.err = 1'b1; // R3
          end else if (!cur.err && cur.pos[0] == 1'b1 &&
                       cur.len[2] == 1'b0) begin
            next_cur.hi = in_byte_in;
          end
          // Data bytes alternate high, low; low completes a word
          next_cur.len[2] = ~cur.len[2];
          if (cur.len[2] && !cur.err && cur.k < cur.cnt) begin
            wr.valid = for_us; // R3 R6
            next_cur.k = cur.k + 16'h0001; // R4
          end
        end
      endcase
      if (cur.pos == srw_pkg::POS_LAST_FIXED) begin
        next_cur.len[2] = 1'b0;
      end
      if (in_last_in) begin
        next_cur.pos = '0;
        done_ok = known_func && !next_cur.err &&
                  cur.pos >= srw_pkg::POS_LAST_FIXED &&
                  (!is_multi || next_cur.k == cur.cnt);
        if (for_us && cur.node != srw_pkg::NODE_BROADCAST &&
            cur.pos != 3'h0) begin
          next_cur.st = srw_pkg::SRW_RESP;
          if (done_ok) begin
            // Echo node, function and the four field bytes
            next_cur.rsp = {cur.node, cur.func, cur.start,
                            next_cur.cnt}; // R7 R9
            next_cur.len = srw_pkg::RSP_LEN_OK;
          end else begin
            next_cur.rsp = {cur.node, cur.func | srw_pkg::EXC_FLAG,
                            known_func ? cur.exc : srw_pkg::EXC_BAD_FUNC,
                            24'h000000}; // R9
            next_cur.len = srw_pkg::RSP_LEN_EXC;
          end
        end else begin
          next_cur.len = '0;
        end
      end
    end else if (cur.st == srw_pkg::SRW_RESP && resp_ready_in) begin
      next_cur.rsp = {cur.rsp[39:0], 8'h00};
      next_cur.len = cur.len - 3'h1;
      if (cur.len == 3'h1) begin
        next_cur.st = srw_pkg::SRW_RX;
        next_cur.len = '0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Write buffer so a stalled register space drops no word
  srw_wr_buf u_buf (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .wr(wr.snk),
    .reg_wr_valid_out(reg_wr_valid_out),
    .reg_wr_addr_out(reg_wr_addr_out),
    .reg_wr_data_out(reg_wr_data_out),
    .reg_wr_ready_in(reg_wr_ready_in)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  logic [15:0] prev_addr;
  always_ff @(posedge clk_sys_in) begin
    if (wr.valid) begin
      prev_addr <= wr.addr;
    end
  end

  a_single_write_addr: assert property ( // R1 R2
    (wr.valid && cur.func == srw_pkg::FN_WRITE_ONE) |->
    (cur.pos == 3'h5 && wr.addr == cur.start && wr.data[7:0] == in_byte_in))
    else $error("single write wrong address or moment");
  a_multi_in_range: assert property ( // R3
    (wr.valid && is_multi) |-> (!cur.err && cur.k < cur.cnt))
    else $error("multi write beyond register count");
  a_multi_addr_step: assert property ( // R4
    (wr.valid && is_multi && cur.k != 16'h0000) |->
    wr.addr == prev_addr + 16'h0001)
    else $error("multi write address did not step by one");
  a_bytecount_check: assert property ( // R5
    (take && cur.pos == 3'h6 && is_multi &&
     in_byte_in != {cur.cnt[6:0], 1'b0}) |=> cur.err)
    else $error("bad byte count accepted");
  a_multi_all_words: assert property ( // R6
    ($rose(resp_valid_out) && cur.len == srw_pkg::RSP_LEN_OK &&
     cur.rsp[39:32] == srw_pkg::FN_WRITE_MANY) |-> cur.k == cur.cnt)
    else $error("multi write echoed before all words applied");
  a_loop_echo: assert property ( // R7
    (take && in_last_in && cur.pos == 3'h5 && for_us &&
     cur.node != srw_pkg::NODE_BROADCAST &&
     cur.func == srw_pkg::FN_LOOPBACK) |=>
    (resp_valid_out && cur.rsp[7:0] == $past(in_byte_in) && !wr.valid))
    else $error("loop-back data not echoed");
  a_exc_flag_set: assert property ( // R9
    ($rose(resp_valid_out) && cur.len == srw_pkg::RSP_LEN_EXC) |->
    (cur.rsp[39] && cur.rsp[31:24] != 8'h00))
    else $error("exception response lacks flag or code");
  a_resp_ends: assert property ( // R9
    (resp_valid_out && resp_ready_in && resp_last_out) |=>
    (!resp_valid_out && in_ready_out == wr.ready))
    else $error("response did not end after last byte");
endmodule // srw_handler
`default_nettype wire

// ### srw_master.sv
// Network master side model: takes response bytes with random stalls
`timescale 1ns/10ps
`default_nettype none
module srw_master (
  // Clock
  input wire logic clk_sys_in,
  // Stall request from the bench
  input wire logic stall_in,
  // Response handshake
  input wire logic resp_valid_in,
  output logic resp_ready_out
);
  // ----------------------------------------------------------------
  // Response acceptance
  // ----------------------------------------------------------------
  // Stalls come off the clock edge so a held byte is really tested
  always_ff @(posedge clk_sys_in) begin
    resp_ready_out <= ~stall_in;
  end
endmodule // srw_master
`default_nettype wire

// ### srw_handler_bench.sv
// Self-checking bench for the serial register write handler
`timescale 1ns/10ps
`default_nettype none
module srw_handler_bench;
  typedef logic [7:0] srw_bq_t[$];
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic in_valid_in = 1'b0;
  logic [7:0] in_byte_in = 8'h00;
  logic in_last_in = 1'b0;
  logic wr_rdy = 1'b0;
  logic stall = 1'b0;
  logic resp_ready;
  wire logic in_ready_out, resp_valid_out, resp_last_out, reg_wr_valid_out;
  wire logic [7:0] resp_byte_out;
  wire logic [15:0] reg_wr_addr_out, reg_wr_data_out;
  logic [31:0] rs = 32'h0A44;
  logic [31:0] rd = 32'h0A44;
  logic [8:0] got[$];
  logic [31:0] wq[$];
  int num_errors = 0;
  int tests_run = 0;
  // ----------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------
  always #4 clk_sys_in = ~clk_sys_in;
  srw_master i_master (.clk_sys_in(clk_sys_in), .stall_in(stall),
    .resp_valid_in(resp_valid_out), .resp_ready_out(resp_ready));
  srw_handler i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .node_id_in(8'h01), .in_valid_in(in_valid_in), .in_byte_in(in_byte_in),
    .in_last_in(in_last_in), .in_ready_out(in_ready_out),
    .resp_valid_out(resp_valid_out), .resp_byte_out(resp_byte_out),
    .resp_last_out(resp_last_out), .resp_ready_in(resp_ready),
    .reg_wr_valid_out(reg_wr_valid_out), .reg_wr_addr_out(reg_wr_addr_out),
    .reg_wr_data_out(reg_wr_data_out), .reg_wr_ready_in(wr_rdy));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Random stalls on both output sides, so the buffer fills up
  always @(posedge clk_sys_in) begin
    #1 rs = lfsr(rs);
    wr_rdy = rs[0] & rs[5];
    stall = rs[2] & rs[3];
  end
  // Collect every accepted response byte and register write
  always @(posedge clk_sys_in) begin
    if (!sys_rst_in && resp_valid_out && resp_ready)
      got.push_back({resp_last_out, resp_byte_out});
    if (!sys_rst_in && reg_wr_valid_out && wr_rdy)
      wq.push_back({reg_wr_addr_out, reg_wr_data_out});
  end
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Offer bytes one by one, holding each until the handler takes it
  task automatic send(input srw_bq_t f);
    logic r;
    // Start off the edge, whatever time the caller returned at
    @(posedge clk_sys_in) #1;
    foreach (f[i]) begin
      in_valid_in = 1'b1;
      in_byte_in = f[i];
      in_last_in = (i == f.size() - 1);
      do begin
        @(negedge clk_sys_in) r = in_ready_out;
        @(posedge clk_sys_in) #1;
      end while (!r);
    end
    in_valid_in = 1'b0;
    in_last_in = 1'b0;
  endtask
  // Reference model, then comparison of the whole transaction
  task automatic run(input srw_bq_t f);
    srw_bq_t er;
    logic [31:0] ew[$];
    logic [15:0] a;
    int n, bc, k, ok;
    ok = 1;
    a = {f[2], f[3]};
    if (f[1] == 8'h06 || f[1] == 8'h08) begin
      if (f[1] == 8'h06) ew.push_back({a, f[4], f[5]});
      er = f[0:5];
    end else if (f[1] == 8'h10) begin
      n = {f[4], f[5]};
      bc = f[6];
      ok = (bc == 2 * n && n > 0 && n < 128);
      // Words land as they arrive, even when extra ones follow
      for (k = 0; ok && k < n && 8 + 2 * k < f.size(); k++)
        ew.push_back({a + 16'(k), f[7 + 2 * k], f[8 + 2 * k]});
      if (ok && f.size() == 7 + bc) er = f[0:5];
      else er = {f[0], 8'h90, 8'h03};
    end else er = {f[0], f[1] | 8'h80, 8'h01};
    if (f[0] != 8'h01) er = {};
    if (f[0] != 8'h01 && f[0] != 8'h00) ew = {};
    got = {};
    wq = {};
    send(f);
    repeat (3) @(posedge clk_sys_in);
    k = 0;
    while (k < 400 && (got.size() < er.size() || wq.size() < ew.size()
        || resp_valid_out || reg_wr_valid_out)) begin
      @(negedge clk_sys_in);
      k++;
    end
    check("settle", k < 400, 1);
    check("resp count", got.size(), er.size());
    foreach (er[i])
      if (i < got.size())
        check("resp byte", got[i], {i == er.size() - 1, er[i]});
    check("write count", wq.size(), ew.size());
    foreach (ew[i]) if (i < wq.size()) check("write", wq[i], ew[i]);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    check("ready after reset", in_ready_out, 1'b1);
    run('{8'h01, 8'h06, 8'h01, 8'h02, 8'h17, 8'h70});
    // Frequency and forward_run in one frame, unused bits zero
    run('{8'h01, 8'h10, 8'h01, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01,
      8'h17, 8'h70});
    run('{8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37});
    run('{8'h01, 8'h10, 8'h01, 8'h01, 8'h00, 8'h02, 8'h03, 8'h00, 8'h01,
      8'h17});
    run('{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01});
    // Zero count, then one extra word after a written one
    run('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    run('{8'h01, 8'h10, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'hAB, 8'hCD,
      8'hEF, 8'h01});
    run('{8'h02, 8'h06, 8'h01, 8'h02, 8'h12, 8'h34});
    run('{8'h00, 8'h06, 8'h01, 8'h03, 8'h56, 8'h78});
    // Random writes and loop-backs; long runs fill the buffer and stall the handler
    repeat (8) begin
      rd = lfsr(rd);
      run('{8'h01, rd[0] ? 8'h06 : 8'h08, rd[15:8], rd[23:16], rd[31:24],
        rd[7:0]});
      rd = lfsr(rd);
      run('{8'h01, 8'h10, rd[15:8], 8'hFE, 8'h00, 8'h04, 8'h08, rd[7:0],
        rd[15:8], rd[23:16], rd[31:24], 8'h00, 8'h11, 8'h22, 8'h33});
    end
    summarize();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    num_errors++;
    summarize();
  end
endmodule // srw_handler_bench
`default_nettype wire
